// ===== pkg/bisd_pkg.sv
`default_nettype none
package bisd_pkg;
  // ----------------------------------------
  // Instruction encoding
  // ----------------------------------------
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int IMM_W = 11;
  localparam logic [2:0] OP_BRANCH = 3'h5;
  localparam logic [5:0] OP_INCR = 6'h0a;
  localparam logic [5:0] OP_SWAP = 6'h0e;
  localparam int DEST_BIT = 7;
  localparam int LATCH_LO = 3;
  localparam int LATCH_HI = 4;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic Z_RST = 1'b0;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } bisd_insn_s;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } bisd_fwr_s;
endpackage : bisd_pkg
`default_nettype wire

// ===== hdl/bisd_core.sv
// Functional notes
// RULE1: Top bits 101 decode as absolute branch
// RULE2: Branch loads immediate into pc bits 10:0
// RULE3: Latch bits 4:3 go to pc 12:11
// RULE4: Branch takes two cycles, flags unchanged
// RULE5: Increment file register, zero flag from result
// RULE6: Increment with d=0 writes working register
// RULE7: Increment with d=1 writes file register
// RULE8: Swap exchanges nibbles, flags unchanged
// RULE9: Swap writes w if d=0, file if d=1
// RULE10: Increment and swap take one cycle
`timescale 1ns/1ps
`default_nettype none
module bisd_core
  import bisd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cycle_en,
  input wire bisd_pkg::bisd_insn_s insn,
  input wire logic [7:0] pc_latch_high,
  input wire logic [7:0] file_rdata,
  output logic [6:0] file_raddr,
  output bisd_pkg::bisd_fwr_s file_wr,
  output logic [12:0] pc,
  output logic [7:0] w_out,
  output logic zero_flag,
  output logic busy
);
  import bisd_pkg::*;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  typedef enum logic [1:0] {ST_RUN = 2'h1, ST_FLUSH = 2'h2} bisd_state_e;
  bisd_state_e state_reg, state_next;
  logic [12:0] pc_reg, pc_next;
  logic [7:0] w_reg, w_next;
  logic z_reg, z_next;
  bisd_fwr_s fwr_reg, fwr_next;
  logic is_branch, is_incr, is_swap, dest_f, take;
  logic [7:0] incr_val, swap_val;

  assign take = cycle_en && insn.valid && (state_reg == ST_RUN);
  assign is_branch = take && (insn.word[13:11] == OP_BRANCH); // RULE1
  assign is_incr = take && (insn.word[13:8] == OP_INCR); // RULE5
  assign is_swap = take && (insn.word[13:8] == OP_SWAP); // RULE8
  assign dest_f = insn.word[DEST_BIT];
  assign file_raddr = insn.word[FADDR_W-1:0];
  assign incr_val = file_rdata + 8'h01; // RULE5
  assign swap_val = {file_rdata[3:0], file_rdata[7:4]}; // RULE8

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    pc_next = pc_reg;
    w_next = w_reg;
    z_next = z_reg;
    fwr_next = '0;
    fwr_next.addr = file_raddr;
    if (cycle_en)
    begin
      unique case (state_reg)
        ST_RUN:
        begin
          if (insn.valid)
          begin
            pc_next = pc_reg + 13'h0001;
          end
          if (is_branch)
          begin
            pc_next = {pc_latch_high[LATCH_HI:LATCH_LO], insn.word[IMM_W-1:0]}; // RULE2 RULE3
            state_next = ST_FLUSH; // RULE4
          end
          else if (is_incr || is_swap) // RULE10
          begin
            if (is_incr)
            begin
              z_next = (incr_val == 8'h00); // RULE5
            end
            if (dest_f)
            begin
              fwr_next.we = 1'b1; // RULE7 RULE9
              fwr_next.data = is_incr ? incr_val : swap_val;
            end
            else
            begin
              w_next = is_incr ? incr_val : swap_val; // RULE6 RULE9
            end
          end
        end
        ST_FLUSH:
        begin
          state_next = ST_RUN; // RULE4
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_RUN;
      pc_reg <= PC_RST;
      w_reg <= W_RST;
      z_reg <= Z_RST;
      fwr_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      w_reg <= w_next;
      z_reg <= z_next;
      fwr_reg <= fwr_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pc = pc_reg;
  assign w_out = w_reg;
  assign zero_flag = z_reg;
  assign file_wr = fwr_reg;
  assign busy = (state_reg == ST_FLUSH);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_branch_target: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
    is_branch |=> pc[10:0] == $past(insn.word[10:0]))
    else $error("branch low pc wrong");

  a_branch_upper: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    is_branch |=> pc[12:11] == $past(pc_latch_high[4:3]))
    else $error("branch upper pc wrong");

  a_branch_two: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    is_branch |=> busy && $stable(zero_flag) ##1 (!busy || !$past(cycle_en)))
    else $error("branch cycle count wrong");

  a_branch_quiet: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    is_branch |=> !file_wr.we && $stable(w_out))
    else $error("branch touched data");

  a_flush_drop: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    busy && cycle_en |=> !busy && !file_wr.we && $stable(pc) && $stable(w_out)
      && $stable(zero_flag))
    else $error("flush cycle not dropped");

  a_decode_branch: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    take && insn.word[13:11] == 3'h5 |=> busy)
    else $error("branch not decoded");

  a_other_skip: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    take && !is_branch && !is_incr && !is_swap |=> pc == $past(pc) + 13'h0001
      && $stable(w_out) && $stable(zero_flag) && !file_wr.we && !busy)
    else $error("other opcode had effect");

  a_incr_zero: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    is_incr |=> zero_flag == ($past(file_rdata) == 8'hff))
    else $error("zero flag wrong");

  a_decode_incr: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    take && insn.word[13:8] == 6'h0a |=> zero_flag == ($past(file_rdata) == 8'hff))
    else $error("increment not decoded");

  a_incr_w: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
    is_incr && !dest_f |=> w_out == $past(file_rdata) + 8'h01 && !file_wr.we)
    else $error("increment to w wrong");

  a_incr_file: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    is_incr && dest_f |=> file_wr.we && file_wr.data == $past(file_rdata) + 8'h01
      && $stable(w_out))
    else $error("increment to file wrong");

  a_swap_flags: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
    is_swap |=> $stable(zero_flag))
    else $error("swap changed flag");

  a_swap_dest: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
    is_swap && !dest_f |=> w_out == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap to w wrong");

  a_swap_file: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
    is_swap && dest_f |=> file_wr.we && file_wr.data == {$past(file_rdata[3:0]),
      $past(file_rdata[7:4])} && $stable(w_out))
    else $error("swap to file wrong");

  a_decode_swap: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
    take && insn.word[13:8] == 6'h0e && insn.word[7] |=> file_wr.we
      && file_wr.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap not decoded");

  a_single_cycle: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
    (is_incr || is_swap) |=> !busy)
    else $error("single cycle op stalled");

  a_pc_step: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
    (is_incr || is_swap) |=> pc == $past(pc) + 13'h0001)
    else $error("pc step wrong");

  a_idle_hold: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
    !cycle_en |=> $stable(pc) && $stable(w_out) && $stable(zero_flag) && !file_wr.we)
    else $error("state moved without enable");

  // ----------------------------------------
  // Covers
  // ----------------------------------------
  c_branch: cover property (@(posedge clock) disable iff (!rst_n) is_branch);
  c_incr_wrap: cover property (@(posedge clock) disable iff (!rst_n)
    is_incr && file_rdata == 8'hff);
  c_swap_file: cover property (@(posedge clock) disable iff (!rst_n) is_swap && dest_f);
  c_flush_drop: cover property (@(posedge clock) disable iff (!rst_n)
    busy && cycle_en && insn.valid);
  c_incr_w: cover property (@(posedge clock) disable iff (!rst_n) is_incr && !dest_f);
endmodule : bisd_core
`default_nettype wire

// ===== bench/bisd_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Program memory
// ------------------------------
module bisd_prog_mem
  import bisd_pkg::*;
(
  input wire logic [12:0] pc,
  output bisd_pkg::bisd_insn_s insn
);
  logic [13:0] mem [16];
  assign insn = '{valid: 1'b1, word: mem[pc[3:0]]};
endmodule : bisd_prog_mem
`default_nettype wire

// ===== bench/branch_increment_swap_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module branch_increment_swap_decode_tb;
  import bisd_pkg::*;
  typedef struct packed {
    logic [13:0] word;
    logic [7:0] rd;
    logic [7:0] w;
    logic z;
    logic we;
    logic [7:0] fd;
  } bisd_row_s;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cycle_en = 1'b0;
  logic [7:0] latch = 8'h00;
  logic [7:0] rdata = 8'h00;
  bisd_insn_s insn;
  bisd_fwr_s file_wr;
  logic [6:0] file_raddr;
  logic [12:0] pc;
  logic [7:0] w_out;
  logic zero_flag;
  logic busy;
  logic [12:0] ep;
  logic [7:0] lh;
  int error_cnt = 0;
  int num_checks = 0;
  bisd_row_s rows [6];
  always #10 clock = ~clock;
  bisd_prog_mem pm_u (.pc(pc), .insn(insn));
  bisd_core dut_u (.clock(clock), .rst_n(rst_n), .cycle_en(cycle_en), .insn(insn),
    .pc_latch_high(latch), .file_rdata(rdata), .file_raddr(file_raddr),
    .file_wr(file_wr), .pc(pc), .w_out(w_out), .zero_flag(zero_flag), .busy(busy));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic step(input logic [13:0] word, input logic [7:0] rd, input logic [7:0] l);
    @(posedge clock);
    pm_u.mem[pc[3:0]] <= word;
    rdata <= rd;
    latch <= l;
    cycle_en <= 1'b1;
    #1;
    chk("raddr", {17'h0, word[6:0]}, {17'h0, file_raddr});
    @(posedge clock);
    cycle_en <= 1'b0;
    #1;
  endtask : step
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    rows = '{'{14'h0a20, 8'h41, 8'h42, 1'b0, 1'b0, 8'h00},
      '{14'h0a20, 8'hff, 8'h00, 1'b1, 1'b0, 8'h00},
      '{14'h0e20, 8'ha5, 8'h5a, 1'b1, 1'b0, 8'h00},
      '{14'h0aa0, 8'h7f, 8'h5a, 1'b0, 1'b1, 8'h80},
      '{14'h0ea0, 8'h3c, 8'h5a, 1'b0, 1'b1, 8'hc3},
      '{14'h0b20, 8'hff, 8'h5a, 1'b0, 1'b0, 8'h00}};
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk("rst", {PC_RST, W_RST, Z_RST, 2'h0}, {pc, w_out, zero_flag, busy, file_wr.we});
    $display("reset done");
    ep = PC_RST;
    foreach (rows[i])
    begin
      step(rows[i].word, rows[i].rd, 8'h00);
      ep = ep + 13'h1;
      chk("pc", {11'h0, ep}, {11'h0, pc});
      chk("wz", {14'h0, rows[i].w, rows[i].z, rows[i].we},
        {14'h0, w_out, zero_flag, file_wr.we});
      if (rows[i].we)
        chk("fwr", {9'h0, 7'h20, rows[i].fd}, {9'h0, file_wr.addr, file_wr.data});
    end
    $display("rows done");
    for (int i = 0; i < 2; i++)
    begin
      lh = i ? 8'h08 : 8'hf7;
      ep = {lh[4:3], i ? 11'h000 : 11'h7ff};
      step(14'h0aa0, i ? 8'hff : 8'h00, 8'h00);
      chk("zset", {23'h0, i[0]}, {23'h0, zero_flag});
      step({3'h5, ep[10:0]}, 8'h00, lh);
      chk("br", {1'b0, ep, 8'h5a, i[0], 1'b1},
        {1'b0, pc, w_out, zero_flag, busy});
      step(14'h0a20, 8'h10, 8'h00);
      chk("flush", {1'b0, ep, 8'h5a, i[0], 1'b0},
        {1'b0, pc, w_out, zero_flag, busy});
    end
    $display("branch done");
    step(14'h0a20, 8'h80, 8'h00);
    chk("pre", {16'h0, 8'h81}, {16'h0, w_out});
    @(posedge clock);
    rst_n <= 1'b0;
    #1;
    chk("rst2", {PC_RST, W_RST, Z_RST, 2'h0}, {pc, w_out, zero_flag, busy, file_wr.we});
    @(posedge clock);
    rst_n <= 1'b1;
    step(14'h0e20, 8'h96, 8'h00);
    chk("post", {PC_RST + 13'h1, 8'h69, 3'h0},
      {pc, w_out, zero_flag, busy, file_wr.we});
    $display("midrun reset done");
    close_out();
  end
endmodule : branch_increment_swap_decode_tb
`default_nettype wire
